// ==== irq_defines.vh ====
// Constants for the priority interrupt controller
`ifndef IRQ_DEFINES_VH
`define IRQ_DEFINES_VH
`define VEC_NMI       12'hffc
`define VEC_SRC1      12'hff6
`define VEC_SRC2      12'hff4
`define VEC_SRC3      12'hff2
`define VEC_SRC4      12'hff0
`define IOR_RESET     8'h00
`define IOR_LES_BIT   6
`define IOR_ESB_BIT   5
`define IOR_GEN_BIT   4
`define MODE_NORMAL   2'd0
`define MODE_IRQ      2'd1
`define MODE_NMI      2'd2
`define LDI_BUG_CYC   3
`define LDI_LEN_CYC   4
`endif

// ==== irq_sync.v ====
// Two-stage synchroniser for pin request lines
module irq_sync #(
  parameter         W       = 5,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input  wire         clk_i,
  input  wire         resetn_i,
  input  wire         ce_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  // Reset to each pin's idle level, else a false edge follows reset
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
    end else if (ce_i) begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
    end
  end
  assign q_o = s2_ff;
endmodule

// ==== event_flags.v ====
// Per-event sticky flags OR-combined onto one request
module event_flags #(
  parameter N = 4
) (
  input  wire         clk_i,
  input  wire         resetn_i,
  input  wire         ce_i,
  input  wire [N-1:0] event_i,
  input  wire [N-1:0] clear_i,
  output reg  [N-1:0] flags_o,
  output wire         any_o
);
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : gen_flag
      always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          flags_o[g] <= 1'b0;
        end else if (ce_i) begin
          // Set wins over a clear in the same cycle
          if (event_i[g]) begin
            flags_o[g] <= 1'b1;
          end else if (clear_i[g]) begin
            flags_o[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  assign any_o = |flags_o;
endmodule

// ==== priority_interrupt_controller.v ====
// Interrupt controller of the core: detection, priority, entry and return
// Overview of operation
// RL1 - One NMI, four maskable, fixed vectors
// RL2 - Accept loads PC with source vector
// RL3 - NMI pre-empts; maskable never nests
// RL4 - Maskable priority fixed, source one first
// RL5 - Global enable off blocks maskable only
// RL6 - Global enable gates wake from stop/wait
// RL7 - NMI served but no wake when disabled
// RL8 - NMI latched, cleared at routine start
// RL9 - Source one level or falling edge
// RL10 - Source two edge, polarity selectable
// RL11 - Sources three, four level sensitive
// RL12 - Edge latch holds one request only
// RL13 - Level requests unstored, held by source
// RL14 - Sample at instruction end, skip next
// RL15 - Per-event flags identify OR-combined sources
// RL16 - Three carry/zero pairs switched on entry
// RL17 - Entry: swap, push, inhibit, clear, vector
// RL18 - Option clear write may skip flag swap
// RL19 - Return restores flags, pops PC
// RL20 - Option register write-only, reset cleared
// RL21 - Maskable pending held during NMI routine
`include "irq_defines.vh"
module priority_interrupt_controller #(
  parameter PC_W  = 12,
  parameter N_EV2 = 4,
  parameter N_EV3 = 4,
  parameter N_EV4 = 4
) (
  input  wire             clk_i,
  input  wire             resetn_i,
  input  wire             ce_i,
  input  wire             nmi_n_i,
  input  wire             src1_n_i,
  input  wire             src2_i,
  input  wire [N_EV2-1:0] ev2_i,
  input  wire [N_EV2-1:0] ev2_clr_i,
  input  wire [N_EV3-1:0] ev3_i,
  input  wire [N_EV3-1:0] ev3_clr_i,
  input  wire [N_EV4-1:0] ev4_i,
  input  wire [N_EV4-1:0] ev4_clr_i,
  input  wire             ior_wr_i,
  input  wire [7:0]       ior_data_i,
  input  wire             instr_end_i,
  input  wire             ldi_ior_clr_i,
  input  wire [1:0]       ldi_cycle_i,
  input  wire             sleep_i,
  input  wire [PC_W-1:0]  pc_i,
  input  wire             return_from_irq_i,
  input  wire             flag_wr_i,
  input  wire             carry_i,
  input  wire             zero_i,
  output reg              take_irq_o,
  output reg  [PC_W-1:0]  vector_o,
  output reg  [PC_W-1:0]  stack_pc_o,
  output reg              push_pc_o,
  output reg              pop_pc_o,
  output reg  [1:0]       mode_o,
  output wire             carry_o,
  output wire             zero_o,
  output reg              wake_o,
  output wire [N_EV2-1:0] ev2_flags_o,
  output wire [N_EV3-1:0] ev3_flags_o,
  output wire [N_EV4-1:0] ev4_flags_o,
  output wire             global_irq_enable_o
);
  localparam [2:0] ST_RUN   = 3'b001;
  localparam [2:0] ST_ENTRY = 3'b010;
  localparam [2:0] ST_SLEEP = 3'b100;

  // Pin inputs pass two flip-flops
  wire [2:0] pins_s;
  irq_sync #(
    .W      (3),
    .RST_VAL(3'b011)
  ) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .d_i      ({src2_i, src1_n_i, nmi_n_i}),
    .q_o      (pins_s)
  );
  wire nmi_n_s  = pins_s[0];
  wire src1_n_s = pins_s[1];
  wire src2_s   = pins_s[2];

  // Peripheral events keep their own flags for polling
  wire any2;
  wire any3;
  wire any4;
  event_flags #(.N(N_EV2)) u_ev2 (
    .clk_i   (clk_i),
    .resetn_i(resetn_i),
    .ce_i    (ce_i),
    .event_i (ev2_i),
    .clear_i (ev2_clr_i),
    .flags_o (ev2_flags_o),
    .any_o   (any2)
  ); // [RL15]
  event_flags #(.N(N_EV3)) u_ev3 (
    .clk_i   (clk_i),
    .resetn_i(resetn_i),
    .ce_i    (ce_i),
    .event_i (ev3_i),
    .clear_i (ev3_clr_i),
    .flags_o (ev3_flags_o),
    .any_o   (any3)
  );
  event_flags #(.N(N_EV4)) u_ev4 (
    .clk_i   (clk_i),
    .resetn_i(resetn_i),
    .ce_i    (ce_i),
    .event_i (ev4_i),
    .clear_i (ev4_clr_i),
    .flags_o (ev4_flags_o),
    .any_o   (any4)
  );

  reg  [7:0]      irq_option_reg_ff;
  reg             nmi_d_ff;
  reg             src1_d_ff;
  reg             src2_d_ff;
  reg             nmi_latch_ff;
  reg             src1_latch_ff;
  reg             src2_latch_ff;
  reg  [2:0]      state_ff;
  reg  [2:0]      sel_ff;
  reg  [1:0]      prev_mode_ff;
  reg             noswap_ff;
  reg             carry_flag_normal_ff;
  reg             zero_flag_normal_ff;
  reg             carry_flag_irq_ff;
  reg             zero_flag_irq_ff;
  reg             carry_nmi_ff;
  reg             zero_nmi_ff;
  reg  [1:0]      flagset_ff;

  wire global_irq_enable  = irq_option_reg_ff[`IOR_GEN_BIT];
  wire src1_level_select  = irq_option_reg_ff[`IOR_LES_BIT];
  wire src2_edge_polarity = irq_option_reg_ff[`IOR_ESB_BIT];
  assign global_irq_enable_o = global_irq_enable;

  wire nmi_fall  = nmi_d_ff & ~nmi_n_s;
  wire src1_fall = src1_d_ff & ~src1_n_s;
  wire src2_edge = src2_edge_polarity ? (~src2_d_ff & src2_s) : (src2_d_ff & ~src2_s); // [RL10]

  // Level requests are read live, never stored
  wire req1 = src1_level_select ? ~src1_n_s : src1_latch_ff; // [RL9] [RL13]
  wire req2 = src2_latch_ff | any2;
  wire req3 = any3; // [RL11]
  wire req4 = any4;
  wire mask_ok = global_irq_enable && (mode_o == `MODE_NORMAL); // [RL5] [RL3] [RL21]
  wire nmi_ok  = nmi_latch_ff && (mode_o != `MODE_NMI); // [RL3]
  wire mask_any = mask_ok && (req1 | req2 | req3 | req4);
  wire any_req  = nmi_ok | mask_any;

  // Source select, NMI above source one above ... source four
  reg [2:0]      nxt_sel;
  reg [PC_W-1:0] nxt_vec;
  always @* begin
    nxt_sel = 3'd0;
    nxt_vec = `VEC_NMI;
    if (nmi_ok) begin
      nxt_sel = 3'd0;
      nxt_vec = `VEC_NMI;
    end else if (req1) begin
      nxt_sel = 3'd1;
      nxt_vec = `VEC_SRC1;
    end else if (req2) begin
      nxt_sel = 3'd2;
      nxt_vec = `VEC_SRC2;
    end else if (req3) begin
      nxt_sel = 3'd3;
      nxt_vec = `VEC_SRC3;
    end else begin
      nxt_sel = 3'd4;
      nxt_vec = `VEC_SRC4;
    end
  end // [RL1] [RL4]

  // Wake needs global enable even for the NMI
  wire wake_req = global_irq_enable &&
                  (nmi_latch_ff || req1 || req2 || req3 || req4); // [RL6] [RL7]
  wire start = (state_ff == ST_RUN) && instr_end_i && any_req; // [RL14]
  // Reproduce the early-cycle option-clear defect
  wire bug_hit = ldi_ior_clr_i && (ldi_cycle_i < `LDI_BUG_CYC) &&
                 (mode_o == `MODE_NORMAL) && !nmi_ok; // [RL18]

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_option_reg_ff <= `IOR_RESET;
      nmi_d_ff          <= 1'b1;
      src1_d_ff         <= 1'b1;
      src2_d_ff         <= 1'b0;
      nmi_latch_ff      <= 1'b0;
      src1_latch_ff     <= 1'b0;
      src2_latch_ff     <= 1'b0;
      state_ff          <= ST_RUN;
      sel_ff            <= 3'd0;
      prev_mode_ff      <= `MODE_NORMAL;
      noswap_ff         <= 1'b0;
      take_irq_o        <= 1'b0;
      vector_o          <= {PC_W{1'b0}};
      stack_pc_o        <= {PC_W{1'b0}};
      push_pc_o         <= 1'b0;
      pop_pc_o          <= 1'b0;
      mode_o            <= `MODE_NORMAL;
      wake_o            <= 1'b0;
      flagset_ff        <= `MODE_NORMAL;
    end else if (ce_i) begin
      take_irq_o <= 1'b0;
      push_pc_o  <= 1'b0;
      pop_pc_o   <= 1'b0;
      wake_o     <= 1'b0;
      nmi_d_ff   <= nmi_n_s;
      src1_d_ff  <= src1_n_s;
      src2_d_ff  <= src2_s;
      if (ior_wr_i) begin
        irq_option_reg_ff <= ior_data_i; // [RL20]
      end
      // Edge latches: one request kept, set beats clear
      if (nmi_fall) begin
        nmi_latch_ff <= 1'b1; // [RL8]
      end else if (state_ff == ST_ENTRY && sel_ff == 3'd0) begin
        nmi_latch_ff <= 1'b0; // [RL8] [RL17]
      end
      if (!src1_level_select && src1_fall) begin
        src1_latch_ff <= 1'b1; // [RL12]
      end else if (src1_level_select ||
                   (state_ff == ST_ENTRY && sel_ff == 3'd1)) begin
        src1_latch_ff <= 1'b0; // [RL12]
      end
      if (src2_edge) begin
        src2_latch_ff <= 1'b1; // [RL12]
      end else if (state_ff == ST_ENTRY && sel_ff == 3'd2) begin
        src2_latch_ff <= 1'b0;
      end
      case (state_ff)
        ST_RUN: begin
          if (sleep_i) begin
            state_ff <= ST_SLEEP;
          end else if (start) begin
            // Swap flag set and push PC in the first entry cycle
            sel_ff       <= nxt_sel;
            vector_o     <= nxt_vec; // [RL2]
            stack_pc_o   <= pc_i;
            push_pc_o    <= 1'b1;
            prev_mode_ff <= mode_o;
            noswap_ff    <= bug_hit && (nxt_sel != 3'd0);
            flagset_ff   <= (nxt_sel == 3'd0) ? `MODE_NMI :
                            (bug_hit ? `MODE_NORMAL : `MODE_IRQ); // [RL16] [RL17] [RL18]
            mode_o       <= (nxt_sel == 3'd0) ? `MODE_NMI : `MODE_IRQ; // [RL17]
            state_ff     <= ST_ENTRY;
          end else if (return_from_irq_i && mode_o != `MODE_NORMAL) begin
            mode_o     <= prev_mode_ff;
            flagset_ff <= prev_mode_ff; // [RL19]
            prev_mode_ff <= `MODE_NORMAL;
            pop_pc_o   <= 1'b1; // [RL19]
          end
        end
        ST_ENTRY: begin
          // Latch cleared above, vector now issued
          take_irq_o <= 1'b1; // [RL17]
          state_ff   <= ST_RUN;
        end
        ST_SLEEP: begin
          if (wake_req) begin
            wake_o   <= 1'b1; // [RL6]
            state_ff <= ST_RUN;
          end
        end
        default: begin
          state_ff <= ST_RUN;
        end
      endcase
    end
  end

  // Three carry/zero pairs, the active one selected by flag set
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      carry_flag_normal_ff <= 1'b0;
      zero_flag_normal_ff  <= 1'b0;
      carry_flag_irq_ff    <= 1'b0;
      zero_flag_irq_ff     <= 1'b0;
      carry_nmi_ff         <= 1'b0;
      zero_nmi_ff          <= 1'b0;
    end else if (ce_i && flag_wr_i) begin
      case (flagset_ff)
        `MODE_IRQ: begin
          carry_flag_irq_ff <= carry_i;
          zero_flag_irq_ff  <= zero_i;
        end
        `MODE_NMI: begin
          carry_nmi_ff <= carry_i;
          zero_nmi_ff  <= zero_i;
        end
        default: begin
          carry_flag_normal_ff <= carry_i;
          zero_flag_normal_ff  <= zero_i;
        end
      endcase
    end
  end // [RL16]

  assign carry_o = (flagset_ff == `MODE_IRQ) ? carry_flag_irq_ff :
                   (flagset_ff == `MODE_NMI) ? carry_nmi_ff : carry_flag_normal_ff;
  assign zero_o  = (flagset_ff == `MODE_IRQ) ? zero_flag_irq_ff :
                   (flagset_ff == `MODE_NMI) ? zero_nmi_ff : zero_flag_normal_ff;
endmodule

// ==== pic_assertions.sv ====
// Port checker for the priority interrupt controller
module pic_checker #(parameter PC_W = 12) (
  input logic            clk_i,
  input logic            resetn_i,
  input logic            instr_end_i,
  input logic [PC_W-1:0] pc_i,
  input logic            return_from_irq_i,
  input logic            ior_wr_i,
  input logic [7:0]      ior_data_i,
  input logic            push_pc_o,
  input logic            take_irq_o,
  input logic            pop_pc_o,
  input logic [PC_W-1:0] vector_o,
  input logic [PC_W-1:0] stack_pc_o,
  input logic [1:0]      mode_o,
  input logic            wake_o,
  input logic            global_irq_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence entry_s;
    push_pc_o ##1 take_irq_o;
  endsequence
  chk_entry_order: assert property (push_pc_o |-> entry_s)
    else $error("vector load missing after push");
  chk_sample_end: assert property (push_pc_o |-> $past(instr_end_i))
    else $error("entry without instruction end");
  chk_saved_pc: assert property (push_pc_o |-> stack_pc_o == $past(pc_i))
    else $error("pushed pc wrong");
  chk_nmi_vector: assert property (push_pc_o && mode_o == 2'd2 |-> vector_o == 12'hffc)
    else $error("nmi vector wrong");
  chk_irq_vector: assert property (push_pc_o && mode_o == 2'd1 |->
    vector_o[11:3] == 9'h1fe && !vector_o[0])
    else $error("maskable vector wrong");
  chk_no_nest: assert property (push_pc_o && $past(mode_o) == 2'd1 |-> mode_o == 2'd2)
    else $error("maskable nested");
  chk_gen_gate: assert property (push_pc_o && mode_o == 2'd1 |-> $past(global_irq_enable_o))
    else $error("maskable taken while disabled");
  chk_wake_gen: assert property (wake_o |-> $past(global_irq_enable_o))
    else $error("wake while disabled");
  chk_return_pop: assert property (return_from_irq_i && mode_o != 2'd0 |=> pop_pc_o)
    else $error("return without pop");
  chk_gen_write: assert property (ior_wr_i && ior_data_i[4] |=> global_irq_enable_o)
    else $error("enable bit not written");
endmodule

// ==== core_model.sv ====
// Core sequencer model: four-cycle instructions and program counter
module core_model (
  input  logic        clk_i,
  input  logic        resetn_i,
  input  logic        take_irq_i,
  input  logic [11:0] vector_i,
  output logic        instr_end_o,
  output logic [11:0] pc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cyc_ff;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cyc_ff <= 2'd0;
      pc_o <= 12'h000;
    end else if (take_irq_i) begin
      cyc_ff <= 2'd0;
      pc_o <= vector_i;
    end else begin
      cyc_ff <= cyc_ff + 2'd1;
      if (cyc_ff == 2'd3) pc_o <= pc_o + 12'h001;
    end
  end
  // Pulse only in the last cycle, as the real core samples there
  assign instr_end_o = (cyc_ff == 2'd3) && resetn_i;
endmodule

// ==== priority_interrupt_controller_tb_top.sv ====
// Testbench for the priority interrupt controller
module priority_interrupt_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {int src; logic [11:0] vec;} row_t;
  row_t rows [5] = '{'{0, 12'hffc}, '{1, 12'hff6}, '{2, 12'hff4}, '{3, 12'hff2}, '{4, 12'hff0}};
  logic clk_i, resetn_i, nmi_n_i, src1_n_i, src2_i, ior_wr_i, ldi_ior_clr_i, sleep_i, return_from_irq_i;
  logic flag_wr_i, carry_i, zero_i, instr_end_i, take_irq_o, push_pc_o, pop_pc_o, wake_o;
  logic carry_o, zero_o, global_irq_enable_o, seen;
  logic [1:0] ldi_cycle_i, mode_o;
  logic [3:0] ev3_i, ev3_clr_i, ev4_i, ev4_clr_i, ev3_flags_o, ev4_flags_o;
  logic [7:0] ior_data_i;
  logic [11:0] pc_i, vector_o, stack_pc_o;
  int error_cnt = 0;
  int check_count = 0;
  int push_cnt = 0;
  int used_cnt = 0;
  // Count entries so one that starts while a request is still driven is not missed
  always @(posedge clk_i) if (push_pc_o === 1'b1) push_cnt++;
  priority_interrupt_controller dut (.clk_i, .resetn_i, .ce_i(1'b1), .nmi_n_i, .src1_n_i,
    .src2_i, .ev2_i(4'h0), .ev2_clr_i(4'h0), .ev3_i, .ev3_clr_i, .ev4_i, .ev4_clr_i, .ior_wr_i,
    .ior_data_i, .instr_end_i, .ldi_ior_clr_i, .ldi_cycle_i, .sleep_i, .pc_i, .return_from_irq_i,
    .flag_wr_i, .carry_i, .zero_i, .take_irq_o, .vector_o, .stack_pc_o, .push_pc_o, .pop_pc_o,
    .mode_o, .carry_o, .zero_o, .wake_o, .ev2_flags_o(), .ev3_flags_o, .ev4_flags_o,
    .global_irq_enable_o);
  core_model core (.clk_i, .resetn_i, .take_irq_i(take_irq_o), .vector_i(vector_o),
    .instr_end_o(instr_end_i), .pc_o(pc_i));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic fire(input int s);
    case (s)
      0: nmi_n_i <= 1'b0;
      1: src1_n_i <= 1'b0;
      2: src2_i <= 1'b1;
      3: ev3_i <= 4'h2;
      default: ev4_i <= 4'h8;
    endcase
    tick(3);
    nmi_n_i <= 1'b1;
    src1_n_i <= 1'b1;
    src2_i <= 1'b0;
    ev3_i <= 4'h0;
    ev4_i <= 4'h0;
  endtask
  task automatic wait_entry(input logic [11:0] vec, input logic [1:0] md);
    int n;
    n = 0;
    while (push_cnt == used_cnt && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    check({vector_o[11:1], push_cnt != used_cnt}, {vec[11:1], 1'b1});
    used_cnt = push_cnt;
    check({10'h0, mode_o}, {10'h0, md});
    tick(3);
  endtask
  task automatic watch(input bit wake, input int n);
    seen = 1'b0;
    repeat (n) begin
      @(negedge clk_i);
      seen = seen | (wake ? wake_o : push_pc_o);
    end
    @(posedge clk_i);
  endtask
  task automatic ret(input logic [1:0] md);
    return_from_irq_i <= 1'b1;
    @(posedge clk_i);
    return_from_irq_i <= 1'b0;
    @(negedge clk_i);
    check({9'h0, pop_pc_o, mode_o}, {9'h1, md});
    @(posedge clk_i);
  endtask
  task automatic irq_option_reg(input logic [7:0] d);
    ior_wr_i <= 1'b1;
    ior_data_i <= d;
    @(posedge clk_i);
    ior_wr_i <= 1'b0;
  endtask
  task automatic clr(input logic [3:0] m3);
    ev3_clr_i <= m3;
    ev4_clr_i <= ~m3;
    @(posedge clk_i);
    ev3_clr_i <= 4'h0;
    ev4_clr_i <= 4'h0;
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {nmi_n_i, src1_n_i, src2_i, ior_wr_i, ldi_ior_clr_i, sleep_i, return_from_irq_i} = 7'b1100000;
    {flag_wr_i, carry_i, zero_i, ldi_cycle_i, ior_data_i, resetn_i} = 14'h0;
    {ev3_i, ev3_clr_i, ev4_i, ev4_clr_i} = 16'h0;
    tick(8);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    check({6'h0, mode_o, take_irq_o, push_pc_o, wake_o, global_irq_enable_o}, 12'h0);
    {flag_wr_i, carry_i, zero_i} <= 3'b111;
    tick(1);
    flag_wr_i <= 1'b0;
    fire(3); // flag holds the level
    fire(4);
    watch(0, 20);
    check({11'h0, seen}, 12'h0);
    check({4'h0, ev3_flags_o, ev4_flags_o}, 12'h028);
    irq_option_reg(8'h30);
    wait_entry(12'hff2, 2'd1);
    fire(0);
    wait_entry(12'hffc, 2'd2);
    clr(4'hf);
    ret(2'd1);
    ret(2'd0);
    wait_entry(12'hff0, 2'd1);
    clr(4'h0);
    ret(2'd0);
    foreach (rows[i]) begin
      fire(rows[i].src);
      wait_entry(rows[i].vec, rows[i].src == 0 ? 2'd2 : 2'd1);
      check({11'h0, carry_o}, 12'h0);
      clr(rows[i].src == 3 ? 4'hf : 4'h0);
      ret(2'd0);
      check({10'h0, carry_o, zero_o}, 12'h3);
    end
    ldi_ior_clr_i <= 1'b1;
    ldi_cycle_i <= 2'd1;
    fire(4);
    wait_entry(12'hff0, 2'd1);
    check({11'h0, carry_o}, 12'h1);
    ldi_ior_clr_i <= 1'b0;
    fire(2);
    fire(2);
    clr(4'h0);
    ret(2'd0);
    wait_entry(12'hff4, 2'd1);
    ret(2'd0);
    watch(0, 20);
    check({11'h0, seen}, 12'h0);
    irq_option_reg(8'h00);
    sleep_i <= 1'b1;
    tick(1);
    sleep_i <= 1'b0;
    fire(0);
    watch(1, 12);
    check({11'h0, seen}, 12'h0);
    irq_option_reg(8'h10);
    watch(1, 12);
    check({11'h0, seen}, 12'h1);
    wait_entry(12'hffc, 2'd2);
    ret(2'd0);
    stop_test();
  end
  initial begin
    #(6000 * 100);
    error_cnt++;
    stop_test();
  end
endmodule
bind priority_interrupt_controller pic_checker #(.PC_W(PC_W)) u_chk (.clk_i, .resetn_i,
  .instr_end_i, .pc_i, .return_from_irq_i, .ior_wr_i, .ior_data_i, .push_pc_o, .take_irq_o, .pop_pc_o,
  .vector_o, .stack_pc_o, .mode_o, .wake_o, .global_irq_enable_o);
